//--- range_frame_pkg.sv
// Constants for the range finder measurement frame encoder.
// Assumes one 40 MHz clock; no bus, every control bit is a plain port.
// How it works
// - Table layout puts quality in bits 2:0, status in 5:3, critical temp in 6, over temp in 7.
// - The over temperature flag is one while the temperature is above 50 degC, else zero.
// - Every quality score from 0 to 100 is reduced to a three bit code from 0 to 6.
// - Scores map in buckets 0-25, 25-50, 50-60, 60-70, 70-80, 80-90, 90-100 onto codes 0 to 6.
// - Status codes are 0 no error, 1 below minimum, 2 out of range, 3 ambient high, 4 invalid.
// - When no distance can be measured the two distance bytes are 0x00 then 0x01.
// - A target closer than the minimum range reports distance 0x0000.
// - A target beyond the maximum range reports distance 0xFFFF.
// - Out of range, high ambient light and invalid readings report distance 0x0001.
// - A below minimum reading with very poor quality may be turned into an invalid reading.
// - Each frame is five bytes: header 0x54, distance high, distance low, status, checksum.
package range_frame_pkg;

  // Frame constants
  localparam logic [7:0]  FRAME_HEADER    = 8'h54;
  localparam int          FRAME_BYTES     = 5;
  localparam logic [7:0]  CRC_INIT        = 8'h00;

  // Distance replacement codes
  localparam logic [15:0] DIST_BELOW_MIN  = 16'h0000;
  localparam logic [15:0] DIST_BEYOND_MAX = 16'hFFFF;
  localparam logic [15:0] DIST_ERROR      = 16'h0001;

  // Temperature thresholds in degC
  localparam logic signed [7:0] OVER_TEMP_C     = 8'sh32;  // 50
  localparam logic signed [7:0] CRITICAL_TEMP_C = 8'sh3C;  // 60

  // Quality bucket lower bounds, score in percent
  localparam logic [6:0]  QF_B1 = 7'h19;  // 25
  localparam logic [6:0]  QF_B2 = 7'h32;  // 50
  localparam logic [6:0]  QF_B3 = 7'h3C;  // 60
  localparam logic [6:0]  QF_B4 = 7'h46;  // 70
  localparam logic [6:0]  QF_B5 = 7'h50;  // 80
  localparam logic [6:0]  QF_B6 = 7'h5A;  // 90

  // Status byte field positions, table layout
  localparam int TBL_QF_LSB   = 0;
  localparam int TBL_ST_LSB   = 3;
  localparam int TBL_CRIT_BIT = 6;
  localparam int TBL_OVER_BIT = 7;
  // Status byte field positions, host decoder layout
  localparam int HST_QF_LSB   = 5;
  localparam int HST_ST_LSB   = 2;
  localparam int HST_CRIT_BIT = 1;
  localparam int HST_OVER_BIT = 0;

  // Measurement status codes
  typedef enum logic [2:0] {
    ST_OK         = 3'h0,
    ST_BELOW_MIN  = 3'h1,
    ST_OUT_RANGE  = 3'h2,
    ST_AMBIENT    = 3'h3,
    ST_INVALID    = 3'h4
  } meas_status_type;

  // Frame sender states
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_HEADER  = 3'b001,
    S_DIST_HI = 3'b010,
    S_DIST_LO = 3'b011,
    S_STATUS  = 3'b100,
    S_CRC     = 3'b101
  } frame_state_type;

endpackage

//--- range_status_byte_encoder.sv
// Measurement frame encoder: status byte, distance error codes, five byte frame.
// Assumes the byte sink (the UART transmitter) takes a byte when valid and ready meet.
// Checksum polynomial is a parameter; the host must be built for the same one.
`timescale 1ns/10ps
module range_status_byte_encoder #(
  parameter logic [7:0] CRC_POLY = 8'h07
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  // Measurement input
  input  wire logic        i_meas_valid,
  output logic             o_meas_ready,
  input  wire logic [15:0] i_distance_mm,
  input  wire logic [6:0]  i_quality_score,
  input  wire logic [2:0]  i_meas_status,
  input  wire logic        i_beyond_max,
  input  wire logic        i_no_distance,
  input  wire logic signed [7:0] i_temperature_c,
  // Configuration
  input  wire logic        i_host_layout,
  input  wire logic        i_poor_reclass_en,
  // Byte stream toward the UART
  output logic             o_byte_valid,
  input  wire logic        i_byte_ready,
  output logic [7:0]       o_byte,
  // Last encoded frame contents
  output logic [7:0]       o_status_byte,
  output logic [15:0]      o_distance_word
);

  range_frame_pkg::frame_state_type state_q;
  range_frame_pkg::frame_state_type state_d;
  logic [7:0]  byte_q;
  logic [7:0]  byte_d;
  logic [7:0]  crc_q;
  logic [7:0]  status_q;
  logic [15:0] dist_q;
  logic [2:0]  qf_code;
  logic [2:0]  st_code;
  logic [15:0] dist_code;
  logic        over_temp;
  logic        crit_temp;
  logic [7:0]  status_byte;
  logic        take_meas;
  logic        byte_taken;
  logic [7:0]  crc_after;

  // One byte step of the frame checksum, MSB first
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Bucket bounds as one table so the comparators can be generated
  localparam logic [6:0] QF_BOUND [6] = '{range_frame_pkg::QF_B1, range_frame_pkg::QF_B2,
                                          range_frame_pkg::QF_B3, range_frame_pkg::QF_B4,
                                          range_frame_pkg::QF_B5, range_frame_pkg::QF_B6};
  logic [5:0] qf_above;

  // One comparator per bound; a score on a bound goes to the upper bucket
  for (genvar b = 0; b < 6; b++) begin : g_qf_bound
    assign qf_above[b] = (i_quality_score >= QF_BOUND[b]);
  end

  // Thermometer to bucket code; scores above 100 clamp to best
  always_comb begin
    case (qf_above)
      6'h00: begin
        qf_code = 3'h0;
      end
      6'h01: begin
        qf_code = 3'h1;
      end
      6'h03: begin
        qf_code = 3'h2;
      end
      6'h07: begin
        qf_code = 3'h3;
      end
      6'h0F: begin
        qf_code = 3'h4;
      end
      6'h1F: begin
        qf_code = 3'h5;
      end
      6'h3F: begin
        qf_code = 3'h6;
      end
      default: begin
        qf_code = 3'h0; // Bounds are ascending, so no other pattern occurs
      end
    endcase
  end

  // Status code; undefined codes fold into invalid so the field stays 0 to 4
  always_comb begin
    if (i_no_distance) begin
      st_code = range_frame_pkg::ST_INVALID;
    end else if (i_meas_status > range_frame_pkg::ST_INVALID) begin
      st_code = range_frame_pkg::ST_INVALID;
    end else if (i_poor_reclass_en && qf_code == 3'h0 &&
                 i_meas_status == range_frame_pkg::ST_BELOW_MIN) begin
      st_code = range_frame_pkg::ST_INVALID;
    end else begin
      st_code = i_meas_status;
    end
  end

  // Distance field, replaced by fixed codes on any error
  always_comb begin
    case (st_code)
      range_frame_pkg::ST_OK: begin
        dist_code = i_distance_mm;
      end
      range_frame_pkg::ST_BELOW_MIN: begin
        dist_code = range_frame_pkg::DIST_BELOW_MIN;
      end
      range_frame_pkg::ST_OUT_RANGE: begin
        // Beyond max is a distinct case from a generic out-of-range failure
        if (i_beyond_max) begin
          dist_code = range_frame_pkg::DIST_BEYOND_MAX;
        end else begin
          dist_code = range_frame_pkg::DIST_ERROR;
        end
      end
      range_frame_pkg::ST_AMBIENT: begin
        dist_code = range_frame_pkg::DIST_ERROR;
      end
      range_frame_pkg::ST_INVALID: begin
        dist_code = range_frame_pkg::DIST_ERROR;
      end
      default: begin
        dist_code = range_frame_pkg::DIST_ERROR;
      end
    endcase
  end

  // Temperature flags, strict greater-than
  assign over_temp = (i_temperature_c > range_frame_pkg::OVER_TEMP_C);
  assign crit_temp = (i_temperature_c > range_frame_pkg::CRITICAL_TEMP_C);

  // Status byte packing; host layout matches the shipped decoder masks
  always_comb begin
    status_byte = 8'h00;
    if (i_host_layout) begin
      status_byte[range_frame_pkg::HST_QF_LSB +: 3] = qf_code;
      status_byte[range_frame_pkg::HST_ST_LSB +: 3] = st_code;
      status_byte[range_frame_pkg::HST_CRIT_BIT]    = crit_temp;
      status_byte[range_frame_pkg::HST_OVER_BIT]    = over_temp;
    end else begin
      status_byte[range_frame_pkg::TBL_QF_LSB +: 3] = qf_code;
      status_byte[range_frame_pkg::TBL_ST_LSB +: 3] = st_code;
      status_byte[range_frame_pkg::TBL_CRIT_BIT]    = crit_temp;
      status_byte[range_frame_pkg::TBL_OVER_BIT]    = over_temp;
    end
  end

  // Measurement handshake; a new measurement waits until the previous frame is gone
  assign o_meas_ready = (state_q == range_frame_pkg::S_IDLE);
  assign take_meas    = i_meas_valid && o_meas_ready;

  // Byte handshake and checksum of the byte on offer
  assign o_byte_valid = (state_q != range_frame_pkg::S_IDLE);
  assign byte_taken   = o_byte_valid && i_byte_ready;
  assign o_byte       = byte_q;
  assign crc_after    = crc_step(crc_q, byte_q);

  // Next state of the frame sender; each byte step waits for the sink
  always_comb begin
    state_d = state_q;
    case (state_q)
      range_frame_pkg::S_IDLE: begin
        if (take_meas) begin
          state_d = range_frame_pkg::S_HEADER;
        end
      end
      range_frame_pkg::S_HEADER: begin
        if (byte_taken) begin
          state_d = range_frame_pkg::S_DIST_HI;
        end
      end
      range_frame_pkg::S_DIST_HI: begin
        if (byte_taken) begin
          state_d = range_frame_pkg::S_DIST_LO;
        end
      end
      range_frame_pkg::S_DIST_LO: begin
        if (byte_taken) begin
          state_d = range_frame_pkg::S_STATUS;
        end
      end
      range_frame_pkg::S_STATUS: begin
        if (byte_taken) begin
          state_d = range_frame_pkg::S_CRC;
        end
      end
      range_frame_pkg::S_CRC: begin
        if (byte_taken) begin
          state_d = range_frame_pkg::S_IDLE;
        end
      end
      default: begin
        state_d = range_frame_pkg::S_IDLE;
      end
    endcase
  end

  // Next frame byte, loaded with the header at acceptance, then as each byte on offer is taken
  always_comb begin
    byte_d = byte_q;
    case (state_q)
      range_frame_pkg::S_IDLE: begin
        if (take_meas) begin
          byte_d = range_frame_pkg::FRAME_HEADER;
        end
      end
      range_frame_pkg::S_HEADER: begin
        if (byte_taken) begin
          byte_d = dist_q[15:8];
        end
      end
      range_frame_pkg::S_DIST_HI: begin
        if (byte_taken) begin
          byte_d = dist_q[7:0];
        end
      end
      range_frame_pkg::S_DIST_LO: begin
        if (byte_taken) begin
          byte_d = status_q;
        end
      end
      range_frame_pkg::S_STATUS: begin
        if (byte_taken) begin
          byte_d = crc_after;
        end
      end
      range_frame_pkg::S_CRC: begin
        if (byte_taken) begin
          byte_d = 8'h00; // Idle output returns to its reset value
        end
      end
      default: begin
        byte_d = byte_q;
      end
    endcase
  end

  // Sender state
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= range_frame_pkg::S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Byte on offer; held unchanged while the sink stalls
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      byte_q <= 8'h00;
    end else begin
      byte_q <= byte_d;
    end
  end

  // Checksum over the first four bytes, restarted with each frame
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      crc_q <= range_frame_pkg::CRC_INIT;
    end else if (take_meas) begin
      crc_q <= range_frame_pkg::CRC_INIT;
    end else if (byte_taken && state_q != range_frame_pkg::S_CRC) begin
      crc_q <= crc_after;
    end
  end

  // Status byte latched at acceptance so later input changes cannot tear a frame
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      status_q <= 8'h00;
    end else if (take_meas) begin
      status_q <= status_byte;
    end
  end

  // Distance word latched on the same edge
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      dist_q <= 16'h0000;
    end else if (take_meas) begin
      dist_q <= dist_code;
    end
  end

  // Last encoded frame contents, straight from the frame registers
  assign o_status_byte   = status_q;
  assign o_distance_word = dist_q;

endmodule

//--- rsbe_chk.sv
// Port-level checker for the measurement frame encoder.
// Bound to the encoder from the testbench; sees its ports only.
`timescale 1ns/10ps
module rsbe_chk (
  // Clock and reset
  input wire logic              i_clock,
  input wire logic              i_rstn,
  // Measurement side
  input wire logic              i_meas_valid,
  input wire logic              o_meas_ready,
  input wire logic [15:0]       i_distance_mm,
  input wire logic [6:0]        i_quality_score,
  input wire logic [2:0]        i_meas_status,
  input wire logic              i_beyond_max,
  input wire logic              i_no_distance,
  input wire logic signed [7:0] i_temperature_c,
  input wire logic              i_host_layout,
  // Byte side and results
  input wire logic              o_byte_valid,
  input wire logic              i_byte_ready,
  input wire logic [7:0]        o_byte,
  input wire logic [7:0]        o_status_byte,
  input wire logic [15:0]       o_distance_word
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // Measurement taken on this edge
  logic tk;
  assign tk = i_meas_valid && o_meas_ready;
  // Frame steps
  sequence hdr_s; o_byte_valid && o_byte == range_frame_pkg::FRAME_HEADER; endsequence
  sequence busy_s; !o_meas_ready [*5]; endsequence
  chk_frame_header: assert property (tk |=> hdr_s) else $error("no header");
  chk_busy_frame: assert property (tk |=> busy_s) else $error("short frame");
  chk_byte_hold: assert property (o_byte_valid && !i_byte_ready |=>
    o_byte_valid && $stable(o_byte)) else $error("byte dropped");
  chk_over_temp: assert property (tk && !i_host_layout |=>
    o_status_byte[7] == ($past(i_temperature_c) > 8'sh32)) else $error("over flag");
  chk_crit_temp: assert property (tk && !i_host_layout |=>
    o_status_byte[6] == ($past(i_temperature_c) > 8'sh3C)) else $error("crit flag");
  chk_below_min: assert property (tk && i_meas_status == 3'h1 && !i_no_distance
    && i_quality_score >= 7'h19 |=> o_distance_word == 16'h0000) else $error("below min");
  chk_beyond_max: assert property (tk && i_meas_status == 3'h2 && i_beyond_max
    && !i_no_distance |=> o_distance_word == 16'hFFFF) else $error("beyond max");
  chk_error_dist: assert property (tk && (i_no_distance || i_meas_status == 3'h3)
    |=> o_distance_word == 16'h0001) else $error("error distance");
  chk_ok_dist: assert property (tk && i_meas_status == 3'h0 && !i_no_distance
    |=> o_distance_word == $past(i_distance_mm)) else $error("distance");
endmodule

//--- host_rx_model.sv
// Host receiver model: takes frame bytes, may stall, decodes with masks.
// Assumes the sender holds byte and valid until ready is sampled.
`timescale 1ns/10ps
module host_rx_model (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rstn,
  // Stall control
  input wire logic        i_stall,
  // Byte stream from the encoder
  input wire logic        i_byte_valid,
  input wire logic [7:0]  i_byte,
  output logic            o_ready,
  // Received frame and decoded fields
  output logic [39:0]     o_frame,
  output int              o_count,
  output logic [7:0]      o_qf,
  output logic [7:0]      o_st
);
  // Slow host takes a byte every other cycle while i_stall is high, else every cycle
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) o_ready <= 1'b0;
    else o_ready <= i_stall ? !o_ready : 1'b1;
  end
  // Last five bytes form the frame
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_frame <= 40'h0;
      o_count <= 0;
    end else if (i_byte_valid && o_ready) begin
      o_frame <= {o_frame[31:0], i_byte};
      o_count <= o_count + 1;
    end
  end
  // Decoder masks on the status byte
  assign o_qf = o_frame[15:8] & 8'hE0;
  assign o_st = o_frame[15:8] & 8'h1C;
endmodule

//--- testbench.sv
// Testbench for the measurement frame encoder with a host model.
// Assumes a 40 MHz clock and inputs driven 1 ns after each edge.
`timescale 1ns/10ps
module testbench;
  logic i_clock, i_rstn, i_meas_valid, i_beyond_max, i_no_distance;
  logic i_host_layout, i_poor_reclass_en, i_byte_ready, o_meas_ready, o_byte_valid, stall;
  logic [15:0] i_distance_mm, o_distance_word;
  logic [6:0] i_quality_score;
  logic [2:0] i_meas_status;
  logic signed [7:0] i_temperature_c;
  logic [7:0] o_byte, o_status_byte, qf, st;
  logic [39:0] frame;
  int cnt, error_cnt, samples_checked;
  range_status_byte_encoder uut (.*);
  host_rx_model host (.i_clock(i_clock), .i_rstn(i_rstn), .i_stall(stall),
    .i_byte_valid(o_byte_valid), .i_byte(o_byte), .o_ready(i_byte_ready),
    .o_frame(frame), .o_count(cnt), .o_qf(qf), .o_st(st));
  // Clock
  always #12.5 i_clock = ~i_clock;
  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // A used-up wait bound ends the run
  task automatic guard(input int k);
    if (k >= 200) begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test;
    end
  endtask
  // Bitwise checksum, polynomial x8+x2+x+1, MSB first, start 0x00
  function automatic logic [7:0] crc8(input logic [31:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // One measurement, one frame, judged against expectations
  task automatic send(input logic [15:0] d, input logic [6:0] q, input logic [2:0] s,
    input logic b, n, input logic signed [7:0] t, input logic h, r);
    logic [2:0] qc, es;
    logic [15:0] ed;
    logic [7:0] eb;
    int k, c0;
    qc = q < 7'h19 ? 3'h0 : q < 7'h32 ? 3'h1 : q < 7'h3C ? 3'h2 : q < 7'h46 ? 3'h3 :
      q < 7'h50 ? 3'h4 : q < 7'h5A ? 3'h5 : 3'h6;
    es = (n || s > 3'h4 || (s == 3'h1 && r && qc == 3'h0)) ? 3'h4 : s;
    ed = es == 3'h0 ? d : es == 3'h1 ? 16'h0000 : (es == 3'h2 && b) ? 16'hFFFF : 16'h0001;
    eb = h ? {qc, es, t > 8'sh3C, t > 8'sh32} : {t > 8'sh32, t > 8'sh3C, es, qc};
    c0 = cnt;
    {i_distance_mm, i_quality_score, i_meas_status, i_beyond_max} = {d, q, s, b};
    {i_no_distance, i_temperature_c, i_host_layout, i_poor_reclass_en} = {n, t, h, r};
    i_meas_valid = 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge i_clock);
      if (o_meas_ready) break;
    end
    guard(k);
    #1 i_meas_valid = 1'b0;
    for (k = 0; k < 200 && cnt < c0 + 5; k++) @(posedge i_clock);
    guard(k);
    #1;
    cmp({16'h0000, o_distance_word}, {16'h0000, ed});
    cmp({24'h000000, o_status_byte}, {24'h000000, eb});
    cmp(frame[39:8], {8'h54, ed, eb});
    cmp({24'h000000, frame[7:0]}, {24'h000000, crc8({8'h54, ed, eb})});
    if (h) cmp({16'h0000, qf, st}, {16'h0000, qc, 5'h00, 3'h0, es, 2'h0});
  endtask
  task automatic t_quality;
    logic [6:0] qs[14] = '{7'h00, 7'h18, 7'h19, 7'h31, 7'h32, 7'h3B, 7'h3C, 7'h45,
      7'h46, 7'h4F, 7'h50, 7'h59, 7'h5A, 7'h64};
    foreach (qs[i]) send(16'h0641, qs[i], 3'h0, 0, 0, 8'sh14, 0, 0);
  endtask
  task automatic t_status;
    for (int s = 0; s < 8; s++) send(16'h1234, 7'h50, 3'(s), 0, 0, 8'sh32, 0, 0);
    send(16'h1234, 7'h50, 3'h2, 1, 0, 8'sh33, 0, 0);
    send(16'h1234, 7'h50, 3'h1, 0, 0, 8'sh3C, 0, 1);
    send(16'hFFFE, 7'h50, 3'h0, 0, 0, 8'sh3D, 0, 0);
  endtask
  task automatic t_errors;
    send(16'h0100, 7'h64, 3'h0, 0, 1, 8'shF6, 0, 0);
    send(16'h0100, 7'h0A, 3'h1, 0, 0, 8'sh00, 0, 1);
    send(16'h0100, 7'h0A, 3'h1, 0, 0, 8'sh00, 0, 0);
  endtask
  // Reset in mid-frame drops the frame and clears every output except o_meas_ready, which goes high
  task automatic t_reset;
    i_meas_valid = 1'b1;
    @(posedge i_clock);
    #1 i_meas_valid = 1'b0;
    @(posedge i_clock);
    #1 i_rstn = 1'b0;
    #1;
    cmp({30'h0, o_byte_valid, o_meas_ready}, 32'h00000001);
    cmp({o_byte, o_status_byte, o_distance_word}, 32'h00000000);
    repeat (2) @(posedge i_clock);
    #1 i_rstn = 1'b1;
  endtask
  task automatic t_host;
    stall = 1'b1;
    send(16'hA55A, 7'h64, 3'h3, 0, 0, 8'sh3D, 1, 0);
    send(16'h0042, 7'h1A, 3'h4, 0, 0, 8'sh33, 1, 0);
    send(16'h0641, 7'h64, 3'h0, 0, 0, 8'sh14, 1, 0);
    stall = 1'b0;
  endtask
  initial begin
    {i_clock, i_rstn, i_meas_valid, i_beyond_max, i_no_distance, stall} = 6'h00;
    {i_host_layout, i_poor_reclass_en, i_distance_mm, i_quality_score} = 25'h0;
    {i_meas_status, i_temperature_c} = 11'h0;
    repeat (6) @(posedge i_clock);
    #1 i_rstn = 1'b1;
    t_quality;
    t_status;
    t_errors;
    t_reset;
    t_host;
    end_of_test;
  end
endmodule
bind range_status_byte_encoder rsbe_chk chk (.*);
